// *** hdl/fsc_pkg.sv ***
package fsc_pkg;

   // Register placement and reset
   localparam logic [7:0]  FILT0_ADDR   = 8'h28;
   localparam logic [15:0] FILT0_RESET  = 16'h0000;
   localparam logic [15:0] NORMAL_MASK  = 16'h8F7F;

   // Field positions
   localparam int DIRECT_BIT  = 15;
   localparam int DEC_MSB     = 14;
   localparam int PF_EN_BIT   = 11;
   localparam int PF_SEL_LSB  = 8;
   localparam int PF_SEL_W    = 3;
   localparam int ORDER_LSB   = 5;
   localparam int ORDER_W     = 2;
   localparam int ODR_LSB     = 0;
   localparam int ODR_W       = 5;

   // Direct sinc3 decimation scale
   localparam int DEC_SCALE   = 32;

   typedef enum logic [1:0] {
      FSC_ORDER_SINC5_SINC1 = 2'h0,
      FSC_ORDER_SINC3       = 2'h3
   } fsc_order_t;

   // Post filter codes
   localparam logic [2:0] PF_27 = 3'h2;
   localparam logic [2:0] PF_25 = 3'h3;
   localparam logic [2:0] PF_20 = 3'h5;
   localparam logic [2:0] PF_16 = 3'h6;

   // Post filter rates in milli samples per second
   localparam int unsigned PF_MSPS_27 = 27000;
   localparam int unsigned PF_MSPS_25 = 25000;
   localparam int unsigned PF_MSPS_20 = 20000;
   localparam int unsigned PF_MSPS_16 = 16670;

   // Post filter settling in tenths of a millisecond
   localparam logic [9:0] PF_SETTLE_27 = 10'h16F;
   localparam logic [9:0] PF_SETTLE_25 = 10'h190;
   localparam logic [9:0] PF_SETTLE_20 = 10'h1F4;
   localparam logic [9:0] PF_SETTLE_16 = 10'h258;

   // Output rate table in milli samples per second
   localparam int         ODR_CODES = 21;
   localparam logic [4:0] ODR_MAX   = 5'h14;
   localparam int unsigned ODR_MSPS [ODR_CODES] = '{
      250000000, 125000000, 62500000, 50000000, 31250000, 25000000, 15625000,
      10000000, 5000000, 2500000, 1000000, 500000, 397500, 200000, 100000,
      59940, 49960, 20000, 16667, 10000, 5000
   };

   // Modulator ticks per output word
   function automatic longint unsigned fsc_ticks(input longint unsigned f_hz,
                                                 input int unsigned     msps);
      longint unsigned q;
      q = (f_hz * 64'd1000) / longint'(msps);
      return q;
   endfunction

endpackage

// *** hdl/fsc_timer_if.sv ***
`timescale 1ns/1ps
interface fsc_timer_if #(parameter int PERIOD_W = 32);
   logic [PERIOD_W-1:0] period;
   logic                restart;
   logic                strobe;
   modport ctl (output period, output restart, input strobe);
   modport tmr (input period, input restart, output strobe);
endinterface

// *** hdl/fsc_rate_timer.sv ***
`timescale 1ns/1ps
module fsc_rate_timer #(
   parameter int PERIOD_W = 32
) (
   input  wire logic    clock,
   input  wire logic    rst,
   input  wire logic    mod_tick,
   fsc_timer_if.tmr     tif
);

   typedef enum logic [1:0] {
      FSC_TMR_IDLE = 2'b01,
      FSC_TMR_RUN  = 2'b10
   } fsc_tmr_state_t;

   fsc_tmr_state_t      state_r;
   fsc_tmr_state_t      state_nxt;
   logic [PERIOD_W-1:0] cnt_r;
   logic [PERIOD_W-1:0] cnt_nxt;
   logic                strobe_r;
   logic                strobe_nxt;

   wire                 period_zero = (tif.period == '0);
   wire                 wrap        = mod_tick && (cnt_r == tif.period - 1'b1);
   wire                 running     = (state_r == FSC_TMR_RUN) && !tif.restart;

   always_comb begin
      case (state_r)
         FSC_TMR_IDLE: state_nxt = period_zero ? FSC_TMR_IDLE : FSC_TMR_RUN;
         FSC_TMR_RUN:  state_nxt = period_zero ? FSC_TMR_IDLE : FSC_TMR_RUN;
         default:      state_nxt = FSC_TMR_IDLE;
      endcase
   end

   // One output word every period modulator ticks
   assign cnt_nxt    = !running ? '0 : (!mod_tick ? cnt_r : (wrap ? '0 : cnt_r + 1'b1)); // R2
   assign strobe_nxt = running && wrap; // R2

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r  <= FSC_TMR_IDLE;
         cnt_r    <= '0;
         strobe_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         strobe_r <= strobe_nxt;
      end
   end

   assign tif.strobe = strobe_r;

   a_idle_quiet: assert property (@(posedge clock) disable iff (rst)
      (state_r == FSC_TMR_IDLE) |=> !strobe_r) // R2
      else $error("strobe while idle");

   a_count_bound: assert property (@(posedge clock) disable iff (rst)
      running |-> (cnt_r < tif.period)) // R2
      else $error("tick count beyond period");

   a_restart_quiet: assert property (@(posedge clock) disable iff (rst)
      tif.restart |=> (!strobe_r && cnt_r == '0)) // R2
      else $error("restart did not clear the count");

endmodule // fsc_rate_timer

// *** hdl/fsc_filter_setup0.sv ***
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// R1: Bit 15 makes bits 14:0 the decimation
// R2: Direct rate is modulator over 32 times value
// R3: Reserved bits 14:12 and 7 read zero
// R4: Bit 11 enables the enhanced post filter
// R5: Post filter works only with order 00
// R6: Post filter codes 010 011 101 110 map
// R7: Order 00 is sinc5 plus sinc1, 11 sinc3
// R8: Host keeps sinc3 and rate across channels
// R9: Rate code 00000 to 10100 picks rate
// R10: Register at 0x28, resets to zero
// R11: Host avoids undocumented codes
module fsc_filter_setup0 #(
   parameter longint unsigned MOD_FREQ_HZ = 64'd8000000,
   parameter int              PERIOD_W    = 32
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [15:0] rd_data,
   input  wire logic        mod_tick,
   output logic             direct_mode,
   output logic      [14:0] dec_value,
   output logic      [1:0]  filter_order,
   output logic             sinc3_active,
   output logic             post_filter_active,
   output logic      [2:0]  post_filter_select,
   output logic      [4:0]  output_rate_code,
   output logic      [9:0]  settle_tenth_ms,
   output logic             sample_strobe
);

   // Elaboration checks
   if (PERIOD_W < 20 || PERIOD_W > 63) begin : g_bad_width
      $error("PERIOD_W must lie between 20 and 63");
   end
   if (MOD_FREQ_HZ == 0) begin : g_bad_freq
      $error("MOD_FREQ_HZ must be nonzero");
   end
   if (fsc_pkg::fsc_ticks(MOD_FREQ_HZ, fsc_pkg::ODR_MSPS[fsc_pkg::ODR_CODES-1])
       >= (64'd1 << PERIOD_W)) begin : g_bad_range
      $error("PERIOD_W too narrow for the slowest rate");
   end

   // Bus decode
   wire               addr_hit = (addr == fsc_pkg::FILT0_ADDR); // R10
   wire               wr_hit   = wr_en && addr_hit;
   wire               rd_hit   = rd_en && addr_hit;

   // In direct mode all of 14:0 is decimation; otherwise reserved bits drop
   wire        [15:0] wr_masked = wr_data[fsc_pkg::DIRECT_BIT] ? wr_data
                                  : (wr_data & fsc_pkg::NORMAL_MASK); // R1 R3

   logic       [15:0] cfg_r;
   logic       [15:0] cfg_nxt;
   logic       [15:0] rd_data_r;
   logic       [15:0] rd_data_nxt;
   logic              restart_r;

   assign cfg_nxt     = wr_hit ? wr_masked : cfg_r;
   assign rd_data_nxt = rd_hit ? cfg_r : 16'h0000;

   // Field split of the next register value
   wire               n_direct = cfg_nxt[fsc_pkg::DIRECT_BIT];
   wire        [14:0] n_dec    = cfg_nxt[fsc_pkg::DEC_MSB:0];
   wire        [1:0]  n_order  = cfg_nxt[fsc_pkg::ORDER_LSB +: fsc_pkg::ORDER_W];
   wire        [2:0]  n_pf_sel = cfg_nxt[fsc_pkg::PF_SEL_LSB +: fsc_pkg::PF_SEL_W];
   wire        [4:0]  n_odr    = cfg_nxt[fsc_pkg::ODR_LSB +: fsc_pkg::ODR_W];
   wire               n_pf_en  = cfg_nxt[fsc_pkg::PF_EN_BIT];

   // Direct mode hides every other field
   wire        [1:0]  n_order_eff = n_direct ? 2'h0 : n_order; // R1 R7
   wire               n_sinc3     = n_direct ||
                                    (n_order == fsc_pkg::FSC_ORDER_SINC3); // R1 R7
   wire               n_pf_active = !n_direct && n_pf_en &&
                                    (n_order == fsc_pkg::FSC_ORDER_SINC5_SINC1); // R4 R5

   wire        [9:0]  n_settle =
      !n_pf_active                ? 10'h000 :
      (n_pf_sel == fsc_pkg::PF_27) ? fsc_pkg::PF_SETTLE_27 :
      (n_pf_sel == fsc_pkg::PF_25) ? fsc_pkg::PF_SETTLE_25 :
      (n_pf_sel == fsc_pkg::PF_20) ? fsc_pkg::PF_SETTLE_20 :
      (n_pf_sel == fsc_pkg::PF_16) ? fsc_pkg::PF_SETTLE_16 : 10'h000; // R6

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_r     <= fsc_pkg::FILT0_RESET; // R10
         rd_data_r <= 16'h0000;
         restart_r <= 1'b0;
      end else begin
         cfg_r     <= cfg_nxt;
         rd_data_r <= rd_data_nxt;
         restart_r <= wr_hit;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         direct_mode        <= 1'b0;
         dec_value          <= 15'h0000;
         filter_order       <= 2'h0;
         sinc3_active       <= 1'b0;
         post_filter_active <= 1'b0;
         post_filter_select <= 3'h0;
         output_rate_code   <= 5'h00;
         settle_tenth_ms    <= 10'h000;
      end else begin
         direct_mode        <= n_direct;
         dec_value          <= n_direct ? n_dec : 15'h0000; // R1
         filter_order       <= n_order_eff; // R7
         sinc3_active       <= n_sinc3; // R7
         post_filter_active <= n_pf_active; // R4 R5
         post_filter_select <= n_direct ? 3'h0 : n_pf_sel;
         output_rate_code   <= n_direct ? 5'h00 : n_odr; // R9
         settle_tenth_ms    <= n_settle; // R6
      end
   end

   assign rd_data = rd_data_r;

   // Ticks per word for each rate code
   logic [PERIOD_W-1:0] odr_div [fsc_pkg::ODR_CODES];
   for (genvar i = 0; i < fsc_pkg::ODR_CODES; i++) begin : g_odr
      localparam longint unsigned TICKS = fsc_pkg::fsc_ticks(MOD_FREQ_HZ, fsc_pkg::ODR_MSPS[i]);
      assign odr_div[i] = TICKS[PERIOD_W-1:0]; // R9
   end

   localparam longint unsigned PF_T27 = fsc_pkg::fsc_ticks(MOD_FREQ_HZ, fsc_pkg::PF_MSPS_27);
   localparam longint unsigned PF_T25 = fsc_pkg::fsc_ticks(MOD_FREQ_HZ, fsc_pkg::PF_MSPS_25);
   localparam longint unsigned PF_T20 = fsc_pkg::fsc_ticks(MOD_FREQ_HZ, fsc_pkg::PF_MSPS_20);
   localparam longint unsigned PF_T16 = fsc_pkg::fsc_ticks(MOD_FREQ_HZ, fsc_pkg::PF_MSPS_16);

   wire               odr_ok    = (output_rate_code <= fsc_pkg::ODR_MAX);
   wire [PERIOD_W-1:0] odr_period = odr_ok ? odr_div[output_rate_code] : '0; // R9

   // Undocumented post filter codes leave the timer stopped
   wire [PERIOD_W-1:0] pf_period =
      (post_filter_select == fsc_pkg::PF_27) ? PF_T27[PERIOD_W-1:0] :
      (post_filter_select == fsc_pkg::PF_25) ? PF_T25[PERIOD_W-1:0] :
      (post_filter_select == fsc_pkg::PF_20) ? PF_T20[PERIOD_W-1:0] :
      (post_filter_select == fsc_pkg::PF_16) ? PF_T16[PERIOD_W-1:0] : '0; // R6

   wire [PERIOD_W-1:0] dir_period = PERIOD_W'(dec_value) *
                                    PERIOD_W'(fsc_pkg::DEC_SCALE); // R2

   wire [PERIOD_W-1:0] period_sel = direct_mode        ? dir_period :
                                    post_filter_active ? pf_period  : odr_period; // R1 R4

   fsc_timer_if #(.PERIOD_W(PERIOD_W)) tif ();

   assign tif.period  = period_sel;
   assign tif.restart = restart_r;

   fsc_rate_timer #(.PERIOD_W(PERIOD_W)) u_timer (
      .clock    (clock),
      .rst      (rst),
      .mod_tick (mod_tick),
      .tif      (tif.tmr)
   );

   assign sample_strobe = tif.strobe;

   a_reset_value: assert property (@(posedge clock) disable iff (rst)
      $fell(rst) |-> (cfg_r == fsc_pkg::FILT0_RESET && !direct_mode)) // R10
      else $error("register not at reset value after reset");

   a_read_back: assert property (@(posedge clock) disable iff (rst)
      (rd_en && addr == fsc_pkg::FILT0_ADDR) |=> (rd_data == $past(cfg_r))) // R10
      else $error("read data differ from register");

   a_unmapped_zero: assert property (@(posedge clock) disable iff (rst)
      !(rd_en && addr == fsc_pkg::FILT0_ADDR) |=> (rd_data == 16'h0000)) // R10
      else $error("read data not zero outside a read");

   a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
      !cfg_r[15] |-> (cfg_r[14:12] == 3'h0 && cfg_r[7] == 1'b0)) // R3
      else $error("reserved bits hold a one");

   a_direct_map: assert property (@(posedge clock) disable iff (rst)
      direct_mode |-> (dec_value == cfg_r[14:0] && !post_filter_active
                       && sinc3_active && output_rate_code == 5'h00)) // R1
      else $error("direct mode fields wrong");

   a_direct_period: assert property (@(posedge clock) disable iff (rst)
      direct_mode |-> (tif.period == {dec_value, 5'h00})) // R2
      else $error("direct period not 32 times value");

   a_post_enable: assert property (@(posedge clock) disable iff (rst)
      $rose(post_filter_active) |-> ($past(wr_en) && cfg_r[11])) // R4
      else $error("post filter enabled without bit 11");

   a_post_order: assert property (@(posedge clock) disable iff (rst)
      (cfg_r[6:5] != 2'h0 || cfg_r[15]) |-> !post_filter_active) // R5
      else $error("post filter active with wrong order");

   a_post_rate: assert property (@(posedge clock) disable iff (rst)
      (post_filter_active && post_filter_select == fsc_pkg::PF_20)
      |-> (tif.period == PF_T20[PERIOD_W-1:0] && settle_tenth_ms == 10'h1F4)) // R6
      else $error("post filter 20 SPS mapping wrong");

   a_order_map: assert property (@(posedge clock) disable iff (rst)
      !cfg_r[15] |-> (filter_order == cfg_r[6:5]
                      && sinc3_active == (cfg_r[6:5] == 2'h3))) // R7
      else $error("filter order output wrong");

   a_rate_code: assert property (@(posedge clock) disable iff (rst)
      (!direct_mode && !post_filter_active && output_rate_code == 5'h00)
      |-> (tif.period == odr_div[0])) // R9
      else $error("fastest rate code period wrong");

endmodule // fsc_filter_setup0

// *** sim/fsc_host_model.sv ***
`timescale 1ns/1ps
// Host side of the register port: drives one request per clock edge
module fsc_host_model (
   input  wire logic        clock,
   output logic      [7:0]  addr,
   output logic      [15:0] wr_data,
   output logic             wr_en,
   output logic             rd_en
);
   initial begin
      addr = 8'h00;
      wr_data = 16'h0000;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end

   // Every request is set after an edge and held until the next edge
   task automatic put(input logic [7:0] a, input logic [15:0] d, input logic w, input logic r);
      addr <= a;
      wr_data <= d;
      wr_en <= w;
      rd_en <= r;
      @(posedge clock);
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
      put(a, d, 1'b1, 1'b0);
   endtask

   task automatic read_reg(input logic [7:0] a);
      put(a, ~wr_data, 1'b0, 1'b1);
   endtask

   task automatic idle();
      put(addr, ~wr_data, 1'b0, 1'b0);
   endtask

   // Random setting that uses only documented codes, single channel
   function automatic logic [15:0] legal_word();
      logic [2:0]  pf_codes [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
      logic [15:0] w;
      w = 16'h0000;
      w[11] = 1'($urandom_range(0, 1));
      w[10:8] = pf_codes[$urandom_range(0, 3)];
      w[6:5] = ($urandom_range(0, 1) != 0) ? 2'h3 : 2'h0;
      w[4:0] = 5'($urandom_range(0, 20));
      return w;
   endfunction
endmodule // fsc_host_model

// *** sim/filter_setup0_config_tb.sv ***
`timescale 1ns/1ps
module filter_setup0_config_tb;
   localparam longint unsigned MOD_FREQ = 64'd5000;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        mod_tick = 1'b0;
   logic [7:0]  addr;
   logic [15:0] wr_data;
   logic        wr_en;
   logic        rd_en;
   logic [15:0] rd_data;
   logic        direct_mode;
   logic [14:0] dec_value;
   logic [1:0]  filter_order;
   logic        sinc3_active;
   logic        post_filter_active;
   logic [2:0]  post_filter_select;
   logic [4:0]  output_rate_code;
   logic [9:0]  settle_tenth_ms;
   logic        sample_strobe;
   logic [37:0] fields;
   logic [15:0] shadow = 16'h0000;
   logic        rd_p = 1'b0;
   logic        wr_p = 1'b0;
   logic        tick_ok = 1'b0;
   int          tick_cnt = 0;
   int          strobe_total = 0;
   int          bad_count = 0;
   int          checked = 0;
   logic [15:0] rd_q [$];
   logic [37:0] fq [$];
   int          sq [$];

   always #2.5 clock = ~clock;

   fsc_host_model host_u (.clock(clock), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
                          .rd_en(rd_en));

   fsc_filter_setup0 #(.MOD_FREQ_HZ(MOD_FREQ), .PERIOD_W(32)) dut_u (
      .clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .mod_tick(mod_tick), .direct_mode(direct_mode),
      .dec_value(dec_value), .filter_order(filter_order), .sinc3_active(sinc3_active),
      .post_filter_active(post_filter_active), .post_filter_select(post_filter_select),
      .output_rate_code(output_rate_code), .settle_tenth_ms(settle_tenth_ms),
      .sample_strobe(sample_strobe));

   assign fields = {direct_mode, dec_value, filter_order, sinc3_active, post_filter_active,
                    post_filter_select, output_rate_code, settle_tenth_ms};

   task automatic fail(input string m);
      $display("Error at %0t: %s", $time, m);
      bad_count++;
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) fail($sformatf("read data %h, expected %h", g, e));
   endtask

   task automatic cmpf(input logic [37:0] e, input logic [37:0] g);
      checked++;
      if (g !== e) fail($sformatf("setting outputs %h, expected %h", g, e));
   endtask

   task automatic cmpn(input int e, input int g);
      checked++;
      if (g != e) fail($sformatf("count %0d, expected %0d", g, e));
   endtask

   function automatic logic [37:0] exp_fields(input logic [15:0] w);
      logic [1:0] o;
      logic       pa;
      logic [9:0] st;
      o = w[6:5];
      pa = w[11] && (o == 2'h0);
      case (w[10:8])
         3'h2: st = 10'h16f;
         3'h3: st = 10'h190;
         3'h5: st = 10'h1f4;
         3'h6: st = 10'h258;
         default: st = 10'h000;
      endcase
      if (!pa) st = 10'h000;
      if (w[15]) return {1'b1, w[14:0], 2'h0, 1'b1, 1'b0, 3'h0, 5'h00, 10'h000};
      return {1'b0, 15'h0000, o, o == 2'h3, pa, w[10:8], w[4:0], st};
   endfunction

   // Output watcher: takes the oldest note whenever a result shows up
   always @(posedge clock) begin
      rd_p <= rd_en;
      wr_p <= wr_en;
      if (rd_p) cmp16(rd_q.pop_front(), rd_data);
      else if (!rst && rd_data !== 16'h0000) fail("read data not idle at zero");
      if (wr_p) cmpf(fq.pop_front(), fields);
      if (sample_strobe) begin
         strobe_total++;
         if (tick_ok && sq.size() > 0) cmpn(sq.pop_front(), tick_cnt);
         tick_ok <= 1'b1;
         tick_cnt <= int'(mod_tick);
      end else begin
         tick_cnt <= tick_cnt + int'(mod_tick);
      end
      if (wr_p || rst) tick_ok <= 1'b0;
   end

   always @(posedge clock) mod_tick <= 1'($urandom_range(0, 1));

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      if (a == 8'h28) shadow = d[15] ? d : (d & 16'h0f7f);
      fq.push_back(exp_fields(shadow));
      host_u.write_reg(a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      rd_q.push_back(a == 8'h28 ? shadow : 16'h0000);
      host_u.read_reg(a);
   endtask

   task automatic wait_strobes(input int p, input int n);
      repeat (n) sq.push_back(p);
      for (int i = 0; i < 4 * p * (n + 2) + 50 && sq.size() > 0; i++) host_u.idle();
      if (sq.size() > 0) begin
         fail("strobe wait ran out");
         end_of_test();
      end
   endtask

   initial begin
      logic [15:0] w;
      void'($urandom(4707));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(8'h28);
      wr(8'h30, 16'hffff);
      rd(8'h29);
      wr(8'h28, 16'h7fff);
      rd(8'h28);
      for (int i = 0; i < 8; i++) wr(8'h28, {4'h0, 1'b1, 3'(i), 8'h00});
      for (int i = 0; i < 8; i++) wr(8'h28, {4'h0, 1'b1, 3'(i), 8'h60});
      wr(8'h28, 16'h0200);
      for (int o = 0; o < 4; o++) wr(8'h28, {9'h000, 2'(o), 5'h14});
      for (int c = 0; c < 21; c++) wr(8'h28, {11'h000, 5'(c)});
      repeat (20) begin
         w = host_u.legal_word();
         wr(8'h28, w);
         rd(8'h28);
      end
      wr(8'h28, 16'hfb63);
      rd(8'h28);
      wr(8'h28, 16'h8001);
      wait_strobes(32, 2);
      wr(8'h28, 16'h8003);
      wait_strobes(96, 2);
      wr(8'h28, 16'h0d14);
      wait_strobes(250, 2);
      wr(8'h28, 16'h0013);
      wait_strobes(500, 1);
      wr(8'h28, 16'h0014);
      wait_strobes(1000, 1);
      wr(8'h28, 16'h0d00);
      host_u.idle();
      rst <= 1'b1;
      repeat (3) host_u.idle();
      rst <= 1'b0;
      shadow = 16'h0000;
      host_u.idle();
      w = 16'(strobe_total);
      repeat (300) host_u.idle();
      cmpn(int'(w), strobe_total);
      rd(8'h28);
      repeat (3) host_u.idle();
      end_of_test();
   end
endmodule // filter_setup0_config_tb
